// file: hdl/dma_pair_regs.svh
`ifndef DMA_PAIR_REGS_SVH
`define DMA_PAIR_REGS_SVH
// register byte offsets
`define PAIR_SLICE_OFS 8'he0
`define PAIR_CFG_OFS 8'he4
`define PAIR_FLAGS_OFS 8'he8
// reset values
`define PAIR_SLICE_RST 32'h0000_0000
`define PAIR_CFG_RST 32'h0000_0000
`define PAIR_FLAGS_RST 32'h0000_0000
// time slice fields, engine d sits one step above engine c
`define SLICE_C_LSB 0
`define SLICE_STEP 16
// config bit positions for engine c, engine d adds CFG_STEP
`define CFG_STEP 16
`define CFG_SRC_ADDR_FMT 15
`define CFG_DST_ADDR_FMT 14
`define CFG_SRC_CMD_FMT 13
`define CFG_DST_CMD_FMT 12
`define CFG_SW_LAST 11
`define CFG_MSG_MODE 10
`define CFG_WORD_STORE 9
`define CFG_FORCE_DST 8
`define CFG_IDLE_POLL_LSB 5
// shared and single bits
`define CFG_POLL_LSB 16
`define CFG_FORCE_DATA_C 3
`define CFG_ACTIVE_LSB 1
`define CFG_PAIR_RUN 0
// event flag positions for engine c, engine d adds FLG_STEP
`define FLG_STEP 8
`define FLG_ABORT 21
`define FLG_DONE 20
`define FLG_LAST 19
`define FLG_WAIT 18
`define FLG_OVF 17
// timing units in engine clocks
`define SLICE_UNIT_CLK 16
`define POLL_UNIT_CLK 16
`define IDLE_UNIT_CLK 256
`endif

// file: hdl/dma_pair_pkg.sv
package dma_pair_pkg;
	// one-hot owner of the shared transfer slot
	typedef enum logic [1:0] {
		ARB_C = 2'b01,
		ARB_D = 2'b10
	} arb_state_t;
endpackage

// file: hdl/dma_pair_control.sv
// Behaviour
// (RL1) slice register: d high half, c low
// (RL2) slice counts 16 clocks, then swap engines
// (RL3) idle or disabled engine yields slot immediately
// (RL4) software keeps slices above poll interval
// (RL5) address format bit selects local or pci
// (RL6) command format bit selects command endianness
// (RL7) software last mode leaves last flag alone
// (RL8) hardware mode: overflow clears flag, advances command
// (RL9) hardware mode: last byte sets last flag
// (RL10) message mode bit selects data or message
// (RL11) word store mode writes param to address
// (RL12) force bit sends destination accesses to pci
// (RL13) engine c force bit sends data to pci
// (RL14) idle poll code times 256, longer wins
// (RL15) shared poll interval in 16 clock units
// (RL16) active bits enable each engine
// (RL17) config bit 0 low resets both engines
// (RL18) protected pci access reads zero, writes dropped
// (RL19) config resets to all zeros
// (RL20) destination abort sets abort flag
// (RL21) done and last flags on destination commands
// (RL22) waiting flag follows destination wait state
// (RL23) overflow with last set flags lost data; code flags it only with software last mode in data mode
// (RL24) flags sticky, write one clears
`timescale 1ns/1ps
`include "dma_pair_regs.svh"

module data_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] count_reg;
	logic push;
	logic pop;

	// full and empty come straight from the fill count
	assign in_ready = count_reg != (AW+1)'(DEPTH);
	assign out_valid = count_reg != '0;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rd_ptr_reg];

	// storage has no reset, only valid entries are ever shown
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end

	// pointers wrap on depth, flush drops everything
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else if (flush) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
			end
			count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

module dma_pair_control #(
	parameter int DATA_W = 32,
	parameter int FIFO_DEPTH = 8
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_from_pci,
	input wire logic protected_mode,
	output logic [31:0] reg_rdata,
	input wire logic [1:0] engine_busy,
	input wire logic [1:0] dst_map_local,
	input wire logic data_map_local_c,
	input wire logic [1:0] dst_cmd_fetch,
	input wire logic [1:0] dst_cmd_last,
	input wire logic [1:0] dst_cmd_done,
	input wire logic [1:0] dst_abort,
	input wire logic [1:0] dst_waiting,
	input wire logic [1:0] dst_buf_overflow,
	input wire logic [1:0] dst_last_byte,
	input wire logic [1:0] word_store_cmd,
	input wire logic [1:0][31:0] word_store_param,
	input wire logic [1:0][31:0] word_store_target,
	output logic pair_reset_n,
	output logic [1:0] engine_enable,
	output logic [1:0] grant,
	output logic [1:0] poll_tick,
	output logic [1:0] src_addr_local,
	output logic [1:0] dst_addr_local,
	output logic [1:0] src_cmd_big_endian,
	output logic [1:0] dst_cmd_big_endian,
	output logic [1:0] message_mode,
	output logic [1:0] dst_on_pci,
	output logic data_on_pci_c,
	output logic [1:0] last_clear,
	output logic [1:0] cmd_advance,
	output logic [1:0] last_set,
	output logic [1:0] word_store_req,
	output logic [1:0][31:0] word_store_addr,
	output logic [1:0][31:0] word_store_data,
	input wire logic src_data_valid,
	output logic src_data_ready,
	input wire logic [DATA_W-1:0] src_data,
	output logic dst_data_valid,
	input wire logic dst_data_ready,
	output logic [DATA_W-1:0] dst_data
);
	logic [31:0] slice_reg;
	logic [31:0] cfg_reg;
	logic [31:0] flags_reg;
	logic [31:0] flag_set;
	logic [31:0] wait_bits;
	logic [4:0] ev [2];
	logic reg_ok;
	logic we;
	dma_pair_pkg::arb_state_t arb_reg;
	logic [3:0] prescale_reg;
	logic [15:0] slice_cnt_reg;
	logic [15:0] slice_cur;
	logic [1:0] want;
	logic cur_d;
	logic expire;
	logic handoff;
	logic unit_tick;
	logic fifo_in_ready;

	// protected pci accesses never reach the registers
	// (RL18) protected access gate
	assign reg_ok = !(protected_mode && reg_from_pci);
	assign we = reg_wr && reg_ok;

	// software registers; slice and config are plain storage
	// (RL1) slice register write
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			slice_reg <= `PAIR_SLICE_RST;
		end else if (we && reg_addr == `PAIR_SLICE_OFS) begin
			slice_reg <= reg_wdata;
		end
	end

	// (RL19) config reset value
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cfg_reg <= `PAIR_CFG_RST;
		end else if (we && reg_addr == `PAIR_CFG_OFS) begin
			cfg_reg <= reg_wdata;
		end
	end

	// set wins over a same-cycle write-one clear
	// (RL24) sticky event flags
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			flags_reg <= `PAIR_FLAGS_RST;
		end else if (we && reg_addr == `PAIR_FLAGS_OFS) begin
			flags_reg <= flag_set | (flags_reg & ~reg_wdata);
		end else begin
			flags_reg <= flags_reg | flag_set;
		end
	end

	// read data one cycle after the strobe, unmapped reads zero
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= '0;
		end else if (!reg_rd || !reg_ok) begin
			reg_rdata <= '0;
		end else if (reg_addr == `PAIR_SLICE_OFS) begin
			reg_rdata <= slice_reg;
		end else if (reg_addr == `PAIR_CFG_OFS) begin
			reg_rdata <= cfg_reg;
		end else if (reg_addr == `PAIR_FLAGS_OFS) begin
			// (RL22) waiting reads live
			reg_rdata <= flags_reg | wait_bits;
		end else begin
			reg_rdata <= '0;
		end
	end

	// (RL17) pair held in reset
	assign pair_reset_n = cfg_reg[`CFG_PAIR_RUN];
	// (RL16) engine enables
	assign engine_enable = cfg_reg[`CFG_ACTIVE_LSB +: 2] & {2{cfg_reg[`CFG_PAIR_RUN]}};
	// (RL13) engine c data routing
	assign data_on_pci_c = cfg_reg[`CFG_FORCE_DATA_C] || !data_map_local_c;

	// arbitration: an engine without work gives up at once
	assign want = engine_enable & engine_busy;
	assign cur_d = arb_reg == dma_pair_pkg::ARB_D;
	assign slice_cur = slice_reg[`SLICE_C_LSB + `SLICE_STEP*cur_d +: 16];
	assign expire = slice_cnt_reg >= slice_cur;
	// (RL3) idle engine yields
	assign handoff = want[!cur_d] && (!want[cur_d] || expire);
	assign unit_tick = prescale_reg == 4'(`SLICE_UNIT_CLK - 1);
	assign grant = arb_reg & want;

	// (RL2) slice unit prescaler
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			prescale_reg <= '0;
			slice_cnt_reg <= '0;
		end else if (handoff) begin
			prescale_reg <= '0;
			slice_cnt_reg <= '0;
		end else begin
			prescale_reg <= prescale_reg + 1'b1;
			if (unit_tick && !expire) begin
				slice_cnt_reg <= slice_cnt_reg + 1'b1;
			end
		end
	end

	// a lone busy engine keeps the slot past its slice
	// (RL2) swap on expiry
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			arb_reg <= dma_pair_pkg::ARB_C;
		end else if (handoff) begin
			case (arb_reg)
				dma_pair_pkg::ARB_C: begin
					arb_reg <= dma_pair_pkg::ARB_D;
				end
				default: begin
					arb_reg <= dma_pair_pkg::ARB_C;
				end
			endcase
		end
	end

	// (RL2) slice expiry hands over
	chk_slice_swap: assert property (@(posedge clk) disable iff (!reset_n) // RL2
		arb_reg == dma_pair_pkg::ARB_C && want == 2'b11 && expire |=> cur_d)
		else $error("slot not passed at slice expiry");
	// (RL3) idle owner passes slot
	chk_idle_yield: assert property (@(posedge clk) disable iff (!reset_n) // RL3
		!cur_d && !want[0] && want[1] |=> cur_d)
		else $error("idle engine kept the slot");
	// (RL17) reset bit holds engines
	chk_pair_hold: assert property (@(posedge clk) disable iff (!reset_n) // RL17
		!cfg_reg[`CFG_PAIR_RUN] |-> !pair_reset_n && engine_enable == 2'b00 && grant == 2'b00)
		else $error("engines live while pair reset");
	// (RL18) protected reads give zero
	chk_prot_read: assert property (@(posedge clk) disable iff (!reset_n) // RL18
		reg_rd && protected_mode && reg_from_pci |=> reg_rdata == 32'h0000_0000)
		else $error("protected read leaked data");
	// (RL18) protected writes dropped
	chk_prot_write: assert property (@(posedge clk) disable iff (!reset_n) // RL18
		reg_wr && protected_mode && reg_from_pci |=> $stable(cfg_reg) && $stable(slice_reg))
		else $error("protected write took effect");

	// per engine options, polling and destination fragment handling
	for (genvar e = 0; e < 2; e++) begin : g_eng
		localparam int CB = `CFG_STEP * e;
		localparam int FB = `FLG_STEP * e;
		logic [10:0] period;
		logic [10:0] poll_cnt_reg;
		logic data_mode;
		logic sw_last;
		logic hw_last;

		// (RL5) address format
		assign src_addr_local[e] = cfg_reg[`CFG_SRC_ADDR_FMT + CB];
		assign dst_addr_local[e] = cfg_reg[`CFG_DST_ADDR_FMT + CB];
		// (RL6) command endianness only
		assign src_cmd_big_endian[e] = cfg_reg[`CFG_SRC_CMD_FMT + CB];
		assign dst_cmd_big_endian[e] = cfg_reg[`CFG_DST_CMD_FMT + CB];
		// (RL10) data or message mode
		assign message_mode[e] = cfg_reg[`CFG_MSG_MODE + CB];
		// (RL12) destination forced to pci
		assign dst_on_pci[e] = cfg_reg[`CFG_FORCE_DST + CB] || !dst_map_local[e];

		// last handling only exists for data mode
		assign data_mode = !message_mode[e];
		assign sw_last = data_mode && cfg_reg[`CFG_SW_LAST + CB];
		assign hw_last = data_mode && !cfg_reg[`CFG_SW_LAST + CB];

		// longer of the shared and the idle poll periods
		// (RL14) idle poll code
		// (RL15) shared poll interval
		always_comb begin
			period = 11'(cfg_reg[`CFG_POLL_LSB +: 5]) * 11'(`POLL_UNIT_CLK);
			if (11'(cfg_reg[`CFG_IDLE_POLL_LSB + CB +: 3]) * 11'(`IDLE_UNIT_CLK) > period) begin
				period = 11'(cfg_reg[`CFG_IDLE_POLL_LSB + CB +: 3]) * 11'(`IDLE_UNIT_CLK);
			end
		end

		// zero period polls every cycle; disabled engines never poll
		always_ff @(posedge clk or negedge reset_n) begin
			if (!reset_n) begin
				poll_cnt_reg <= '0;
				poll_tick[e] <= 1'b0;
			end else if (!engine_enable[e]) begin
				poll_cnt_reg <= '0;
				poll_tick[e] <= 1'b0;
			end else if (poll_cnt_reg >= period) begin
				poll_cnt_reg <= '0;
				poll_tick[e] <= 1'b1;
			end else begin
				poll_cnt_reg <= poll_cnt_reg + 1'b1;
				poll_tick[e] <= 1'b0;
			end
		end

		// in software mode an overflow moves on only if last is clear
		// (RL7) software mode untouched
		// (RL8) overflow clears and advances
		// (RL9) last byte sets flag
		always_ff @(posedge clk or negedge reset_n) begin
			if (!reset_n) begin
				last_clear[e] <= 1'b0;
				cmd_advance[e] <= 1'b0;
				last_set[e] <= 1'b0;
			end else begin
				last_clear[e] <= hw_last && dst_buf_overflow[e];
				cmd_advance[e] <= dst_buf_overflow[e] && (hw_last || (sw_last && !dst_cmd_last[e]));
				last_set[e] <= hw_last && dst_last_byte[e];
			end
		end

		// (RL11) word store write
		always_ff @(posedge clk or negedge reset_n) begin
			if (!reset_n) begin
				word_store_req[e] <= 1'b0;
				word_store_addr[e] <= '0;
				word_store_data[e] <= '0;
			end else begin
				word_store_req[e] <= cfg_reg[`CFG_WORD_STORE + CB] && engine_enable[e]
					&& word_store_cmd[e];
				if (word_store_cmd[e]) begin
					word_store_addr[e] <= word_store_target[e];
					word_store_data[e] <= word_store_param[e];
				end
			end
		end

		// event sources for the flags register
		// (RL20) abort event
		// (RL21) done and last events
		// (RL23) lost data event
		assign ev[e] = {dst_abort[e], dst_cmd_done[e], dst_cmd_fetch[e] && dst_cmd_last[e],
			1'b0, sw_last && dst_buf_overflow[e] && dst_cmd_last[e]};

		sequence s_hw_ovf;
			hw_last && dst_buf_overflow[e];
		endsequence
		// (RL8) hardware overflow response
		chk_hw_advance: assert property (@(posedge clk) disable iff (!reset_n) // RL8
			s_hw_ovf |=> last_clear[e] && cmd_advance[e] && last_set[e] == $past(dst_last_byte[e]))
			else $error("overflow did not advance command");
		// (RL7) software mode leaves flag
		chk_sw_keep: assert property (@(posedge clk) disable iff (!reset_n) // RL7
			sw_last || message_mode[e] |=> !last_clear[e] && !last_set[e])
			else $error("last flag altered outside hardware mode");
		// (RL14) no back-to-back polls
		chk_poll_gap: assert property (@(posedge clk) disable iff (!reset_n) // RL14
			poll_tick[e] && period != 11'h000 && $stable(cfg_reg) |=> !poll_tick[e])
			else $error("poll ticks closer than period");
		// (RL23) lost data flagged
		chk_lost_flag: assert property (@(posedge clk) disable iff (!reset_n) // RL23
			sw_last && dst_buf_overflow[e] && dst_cmd_last[e] |=> flags_reg[`FLG_OVF + FB])
			else $error("overflow loss not flagged");
		// (RL12) forced destination on pci
		chk_force_dst: assert property (@(posedge clk) disable iff (!reset_n) // RL12
			cfg_reg[`CFG_FORCE_DST + CB] |-> dst_on_pci[e])
			else $error("forced destination not on pci");
	end

	// gather both engines' events at their flag positions
	always_comb begin
		flag_set = '0;
		wait_bits = '0;
		for (int i = 0; i < 2; i++) begin
			flag_set[`FLG_ABORT + `FLG_STEP*i] = ev[i][4];
			flag_set[`FLG_DONE + `FLG_STEP*i] = ev[i][3];
			flag_set[`FLG_LAST + `FLG_STEP*i] = ev[i][2];
			flag_set[`FLG_OVF + `FLG_STEP*i] = ev[i][0];
			wait_bits[`FLG_WAIT + `FLG_STEP*i] = dst_waiting[i];
		end
	end

	// (RL24) flag survives without clear
	chk_flag_sticky: assert property (@(posedge clk) disable iff (!reset_n) // RL24
		flags_reg[`FLG_DONE] && !(we && reg_addr == `PAIR_FLAGS_OFS && reg_wdata[`FLG_DONE])
		|=> flags_reg[`FLG_DONE])
		else $error("done flag dropped without clear");

	// no ready while held in reset, else a source would see dropped words as taken
	// (RL17) source side blocked in pair reset
	assign src_data_ready = fifo_in_ready && pair_reset_n;

	// stream buffer; flushed while the pair is held in reset
	data_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.reset_n(reset_n),
		.flush(!pair_reset_n),
		.in_valid(src_data_valid && pair_reset_n),
		.in_ready(fifo_in_ready),
		.in_data(src_data),
		.out_valid(dst_data_valid),
		.out_ready(dst_data_ready),
		.out_data(dst_data)
	);
endmodule

// file: sim/engine_sink_model.sv
`timescale 1ns/1ps
// far-side consumer of the destination stream, stalls on request
module engine_sink_model (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic stall,
	input wire logic dst_data_valid,
	input wire logic [31:0] dst_data,
	output logic dst_data_ready
);
	logic [31:0] rx_q[$];

	// ready follows stall one edge late, like a real sink that decides late
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			dst_data_ready <= 1'b0;
		end else begin
			if (dst_data_valid && dst_data_ready) begin
				rx_q.push_back(dst_data);
			end
			dst_data_ready <= !stall;
		end
	end
endmodule

// file: sim/dual_dma_pair_control_tb_top.sv
`timescale 1ns/1ps
`include "dma_pair_regs.svh"
module dual_dma_pair_control_tb_top;
	logic clk, reset_n, reg_wr, reg_rd, reg_from_pci, protected_mode, data_map_local_c;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, src_data, dst_data, d;
	logic [1:0] engine_busy, dst_map_local, dst_cmd_fetch, dst_cmd_last, dst_cmd_done, dst_abort;
	logic [1:0] dst_waiting, dst_buf_overflow, dst_last_byte, word_store_cmd, engine_enable;
	logic [1:0][31:0] word_store_param, word_store_target, word_store_addr, word_store_data;
	logic pair_reset_n, data_on_pci_c, src_data_valid, src_data_ready, dst_data_valid;
	logic dst_data_ready, stall, r;
	logic [1:0] grant, poll_tick, src_addr_local, dst_addr_local, src_cmd_big_endian;
	logic [1:0] dst_cmd_big_endian, message_mode, dst_on_pci, last_clear, cmd_advance, last_set;
	logic [1:0] word_store_req;
	int n_mismatch, cmp_count, k, n;
	typedef struct {logic [31:0] cfg; logic [2:0] map; logic [15:0] exp;} row_t;
	// expected: pair run, data pci, dst pci, enable, msg, dst be, src be, dst local, src local
	row_t rows[8] = '{'{32'h8000_0007, 3'h7, 16'h8c02}, '{32'h4000_8003, 3'h7, 16'h8409},
		'{32'h2000_4005, 3'h7, 16'h8824}, '{32'h1000_2001, 3'h7, 16'h8090},
		'{32'h0400_1007, 3'h7, 16'h8e40}, '{32'h0000_0406, 3'h7, 16'h0100},
		'{32'h0100_0109, 3'h7, 16'hf000}, '{32'h0000_0001, 3'h2, 16'hd000}};

	dma_pair_control #(.DATA_W(32), .FIFO_DEPTH(8)) i_dut (.*);
	engine_sink_model i_model (.*);

	// free-running bench clock, 100 ns period
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task print_verdict();
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// strobe held for exactly one sampling edge
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask

	// one-cycle event pulses, outputs settled on return
	task pulse(input logic [1:0] ab, dn, fe, ov, lb, ws);
		@(posedge clk);
		dst_abort <= ab;
		dst_cmd_done <= dn;
		dst_cmd_fetch <= fe;
		dst_buf_overflow <= ov;
		dst_last_byte <= lb;
		word_store_cmd <= ws;
		@(posedge clk);
		{dst_abort, dst_cmd_done, dst_cmd_fetch, dst_buf_overflow, dst_last_byte} <= '0;
		word_store_cmd <= 2'b00;
		#1;
	endtask

	// bounded wait for grant g, then length of its run
	task span(input logic [1:0] g, output int len);
		for (k = 0; k < 500 && grant !== g; k++) begin
			@(posedge clk);
			#1;
		end
		for (len = 0; len < 500 && grant === g; len++) begin
			@(posedge clk);
			#1;
		end
	endtask

	task tick_gap(input int e, output int len);
		for (k = 0; k < 3000 && poll_tick[e] !== 1'b1; k++) begin
			@(posedge clk);
			#1;
		end
		len = 0;
		do begin
			@(posedge clk);
			#1;
			len++;
		end while (poll_tick[e] !== 1'b1 && len < 3000);
	endtask

	// watchdog sized well above the expected run of under 2000 cycles
	initial begin
		#3000000;
		n_mismatch++;
		print_verdict();
	end

	initial begin
		{reg_wr, reg_rd, reg_from_pci, protected_mode, data_map_local_c, stall} = '0;
		{reg_addr, reg_wdata, src_data, src_data_valid} = '0;
		{engine_busy, dst_map_local, dst_cmd_fetch, dst_cmd_last, dst_cmd_done} = '0;
		{dst_abort, dst_waiting, dst_buf_overflow, dst_last_byte, word_store_cmd} = '0;
		word_store_param = {32'h0bad_0002, 32'ha5a5_0001};
		word_store_target = {32'h0000_0200, 32'h0000_0100};
		reset_n = 1'b0;
		repeat (20) @(posedge clk);
		chk("reset outputs", {pair_reset_n, engine_enable, src_data_ready}, 0);
		reset_n <= 1'b1;
		for (k = 0; k < 3; k++) begin
			rd(8'he0 + 8'(k * 4), d);
			chk("reset value", d, 0);
		end
		rd(8'hf0, d);
		chk("unmapped", d, 0);
		// table of config patterns against decoded outputs
		foreach (rows[i]) begin
			@(posedge clk);
			{data_map_local_c, dst_map_local} <= rows[i].map;
			wr(`PAIR_CFG_OFS, rows[i].cfg);
			#1;
			chk("decode", {pair_reset_n, data_on_pci_c, dst_on_pci, engine_enable, message_mode,
				dst_cmd_big_endian, src_cmd_big_endian, dst_addr_local, src_addr_local},
				rows[i].exp);
			rd(`PAIR_CFG_OFS, d);
			chk("cfg readback", d, rows[i].cfg);
		end
		dst_map_local <= 2'b11;
		// protected pci access is refused both ways
		wr(`PAIR_CFG_OFS, 32'h0000_0807);
		reg_from_pci <= 1'b1;
		protected_mode <= 1'b1;
		wr(`PAIR_CFG_OFS, 32'h0000_0001);
		rd(`PAIR_CFG_OFS, d);
		chk("protected read", d, 0);
		protected_mode <= 1'b0;
		rd(`PAIR_CFG_OFS, d);
		chk("protected write", d, 32'h0000_0807);
		reg_from_pci <= 1'b0;
		// software last mode on both, last flag already set on c
		wr(`PAIR_CFG_OFS, 32'h0800_0807);
		dst_cmd_last <= 2'b01;
		pulse(2'b01, 2'b10, 2'b01, 2'b01, 2'b00, 2'b00);
		chk("sw no advance", {last_clear, cmd_advance}, 0);
		dst_waiting <= 2'b10;
		rd(`PAIR_FLAGS_OFS, d);
		chk("flags set", d, 32'h142a_0000);
		wr(`PAIR_FLAGS_OFS, 32'h0000_0000);
		rd(`PAIR_FLAGS_OFS, d);
		chk("flags zero write", d, 32'h142a_0000);
		wr(`PAIR_FLAGS_OFS, 32'h0020_0000);
		dst_waiting <= 2'b00;
		rd(`PAIR_FLAGS_OFS, d);
		chk("flags one clear", d, 32'h100a_0000);
		wr(`PAIR_FLAGS_OFS, 32'hffff_ffff);
		// hardware last mode ignores the set last flags
		dst_cmd_last <= 2'b11;
		wr(`PAIR_CFG_OFS, 32'h0000_0007);
		pulse(2'b00, 2'b00, 2'b00, 2'b10, 2'b01, 2'b00);
		chk("hw fragment", {last_clear, cmd_advance, last_set}, 6'b10_10_01);
		rd(`PAIR_FLAGS_OFS, d);
		chk("hw no loss", d, 0);
		wr(`PAIR_CFG_OFS, 32'h0000_0407);
		pulse(2'b00, 2'b00, 2'b00, 2'b01, 2'b01, 2'b00);
		chk("msg no fragment", {last_clear, cmd_advance, last_set}, 0);
		// word store enabled on c only
		wr(`PAIR_CFG_OFS, 32'h0000_0207);
		pulse(2'b00, 2'b00, 2'b00, 2'b00, 2'b00, 2'b11);
		chk("ws req", word_store_req, 2'b01);
		chk("ws addr", word_store_addr[0], 32'h0000_0100);
		chk("ws data", word_store_data[0], 32'ha5a5_0001);
		// slices of 2 and 3 units, c equal to and d above poll interval 2
		wr(`PAIR_SLICE_OFS, 32'h0003_0002);
		wr(`PAIR_CFG_OFS, 32'h0002_0007);
		engine_busy <= 2'b11;
		span(2'b01, n);
		span(2'b10, n);
		chk("slice d", n >= 48 && n <= 50, 1);
		span(2'b01, n);
		chk("slice c", n >= 32 && n <= 34, 1);
		// owner d goes idle early in its slice, then owner c does
		@(posedge clk);
		engine_busy <= 2'b01;
		@(posedge clk);
		#1 chk("idle d yields", grant, 2'b01);
		@(posedge clk);
		engine_busy <= 2'b10;
		@(posedge clk);
		#1 chk("idle c yields", grant, 2'b10);
		// longer of idle poll and shared poll wins
		tick_gap(0, n);
		tick_gap(0, n);
		chk("poll shared", n, 33);
		wr(`PAIR_CFG_OFS, 32'h0002_0027);
		tick_gap(0, n);
		tick_gap(0, n);
		chk("poll idle", n, 257);
		tick_gap(1, n);
		tick_gap(1, n);
		chk("poll d shared", n, 33);
		// fill the buffer against a stalled sink
		stall <= 1'b1;
		repeat (3) @(posedge clk);
		src_data_valid <= 1'b1;
		src_data <= 32'h0000_0100;
		n = 0;
		for (int j = 0; j < 12; j++) begin
			#1 r = src_data_ready;
			@(posedge clk);
			if (r === 1'b1) begin
				n++;
				src_data <= 32'h0000_0100 + 32'(n);
			end
		end
		src_data_valid <= 1'b0;
		chk("fill count", n, 8);
		stall <= 1'b0;
		repeat (4) @(posedge clk);
		stall <= 1'b1;
		repeat (3) @(posedge clk);
		stall <= 1'b0;
		repeat (20) @(posedge clk);
		chk("drain count", i_model.rx_q.size(), 8);
		foreach (i_model.rx_q[i]) begin
			chk("drain data", i_model.rx_q[i], 32'h0000_0100 + 32'(i));
		end
		#1 chk("drained", dst_data_valid, 0);
		// disable engines before holding the pair in reset
		wr(`PAIR_CFG_OFS, 32'h0000_0001);
		wr(`PAIR_CFG_OFS, 32'h0000_0000);
		#1 chk("pair held", {pair_reset_n, src_data_ready, engine_enable}, 0);
		print_verdict();
	end
endmodule
